// File: dv/ses_core_model.sv
// behavioural processor core that takes offered exceptions, runs a handler and returns
`timescale 1ns/1ps
`default_nettype none
module ses_core_model (
	// clock and take permission
	input wire logic sys_clk,
	input wire logic take_en,
	// offer from the controller
	input wire logic exc_req,
	input wire ses_pkg::ses_exc_num_type exc_num,
	// acknowledge and return
	output logic exc_ack,
	output ses_pkg::ses_exc_num_type exc_ack_num,
	output logic exc_return,
	output ses_pkg::ses_exc_num_type exc_return_num
);
	import ses_pkg::*;
	ses_exc_num_type taken;

	// released numbers show their inverse so a stale value never looks valid
	initial begin
		exc_ack = 1'b0;
		exc_return = 1'b0;
		exc_ack_num = 5'h1f;
		exc_return_num = 5'h1f;
		forever begin
			@(negedge sys_clk);
			if (take_en && exc_req === 1'b1) begin
				taken = exc_num;
				exc_ack = 1'b1;
				exc_ack_num = taken;
				@(negedge sys_clk);
				exc_ack = 1'b0;
				exc_ack_num = ~taken;
				repeat (4) @(negedge sys_clk);
				exc_return = 1'b1;
				exc_return_num = taken;
				@(negedge sys_clk);
				exc_return = 1'b0;
				exc_return_num = ~taken;
			end
		end
	end
endmodule : ses_core_model
`default_nettype wire

// File: dv/system_exception_sources_tb.sv
// self-checking bench of the system exception source logic
`timescale 1ns/1ps
`default_nettype none
module system_exception_sources_tb;
	import ses_pkg::*;
	// clock, reset and core handshake
	logic sys_clk, rst_b, take_en, ack, ret;
	ses_exc_num_type ack_num, ret_num, exc_num;
	// controls driven by the bench
	logic icsr_wr, nmi_set, def_set, def_clr, tk_set, tk_clr, handler_control_state_reg_wr, svc_bit;
	logic sysreq_wr, sys_bit, vtab_wr, vtab_ram, undef_f, bad_f, svc_ins;
	logic tick_en, tick_ie, tick_clr;
	logic [31:0] hpr2, hpr3, irq_prio;
	logic [15:0] irq_en;
	logic [23:0] reload, tick_cnt;
	logic [15:0][3:0] line_st;
	// observed outputs
	logic boot_act, exc_req, vec_rom, nmi_ps, sys_ps, flt_ps, svc_ps, def_ps, tk_ps, vtab_sel;
	logic [31:0] vec;
	logic [15:0] irq_ps;
	int fail_count, comparisons;
	ses_exc_num_type seen[$];

	ses_exc_top ses_exc_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .boot_rom_active(boot_act),
		.exc_req(exc_req), .exc_num(exc_num), .exc_vector_addr(vec), .exc_vector_boot_rom(vec_rom),
		.exc_ack(ack), .exc_ack_num(ack_num), .exc_return(ret), .exc_return_num(ret_num),
		.undef_instr_fault(undef_f), .bad_addr_fault(bad_f),
		.supervisor_call_instruction(svc_ins), .icsr_wr(icsr_wr), .nmi_pend_set_bit(nmi_set),
		.deferred_service_set_bit(def_set), .deferred_service_clear_bit(def_clr),
		.tick_pending_set(tk_set), .tick_pending_clear(tk_clr), .handler_control_state_reg_wr(handler_control_state_reg_wr),
		.supervisor_call_pended_bit(svc_bit), .sysreq_wr(sysreq_wr),
		.system_call_request_bit(sys_bit), .vtab_wr(vtab_wr), .vtab_ram_select(vtab_ram),
		.handler_priority_reg2(hpr2), .handler_priority_reg3(hpr3), .irq_priority(irq_prio),
		.irq_enable(irq_en), .tick_enable(tick_en), .tick_interrupt_enable(tick_ie),
		.tick_count_clear(tick_clr), .tick_reload(reload), .gpio_port_status(line_st[3:0]),
		.gpio_all_status(line_st[4]), .comparator_status(line_st[5]),
		.watchdog_status(line_st[6]), .serial_status(line_st[8:7]),
		.programming_interface_status(line_st[9]), .capacitive_sensing_status(line_st[10]),
		.timer_status(line_st[15:11]), .nmi_pend_state(nmi_ps), .system_call_state(sys_ps),
		.fault_pend_state(flt_ps), .supervisor_call_pend_state(svc_ps),
		.deferred_service_pend_state(def_ps), .tick_pend_state(tk_ps), .irq_pend_state(irq_ps),
		.vtab_ram_selected(vtab_sel), .tick_count(tick_cnt));

	ses_core_model ses_core_model_inst (.sys_clk(sys_clk), .take_en(take_en), .exc_req(exc_req),
		.exc_num(exc_num), .exc_ack(ack), .exc_ack_num(ack_num), .exc_return(ret),
		.exc_return_num(ret_num));

	// 40 mhz clock
	always #12.5 sys_clk = ~sys_clk;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	// write strobe with its bit, then a quiet cycle so calls never collide in one step
	task automatic wr(ref logic stb, ref logic b, input logic v);
		b = v;
		stb = 1'b1;
		cyc(1);
		stb = 1'b0;
		b = 1'b0;
		cyc(1);
	endtask : wr

	// bits in order: nmi set, deferred set, deferred clear, tick set, tick clear
	task automatic icsr(input logic [4:0] b);
		{nmi_set, def_set, def_clr, tk_set, tk_clr} = b;
		icsr_wr = 1'b1;
		cyc(1);
		icsr_wr = 1'b0;
		{nmi_set, def_set, def_clr, tk_set, tk_clr} = 5'h00;
		cyc(1);
	endtask : icsr

	task automatic wait_num(input ses_exc_num_type n, input logic [31:0] v);
		repeat (40) if (!(exc_req === 1'b1 && exc_num === n)) cyc(1);
		chk("exc_req", 32'h1, exc_req);
		chk("exc_num", n, exc_num);
		chk("vector", v, vec);
	endtask : wait_num

	// the core takes offers for n cycles; the order of its acknowledges is logged
	task automatic drain(input int n, input ses_exc_num_type e[$]);
		seen.delete();
		take_en = 1'b1;
		repeat (n) begin
			@(posedge sys_clk);
			if (ack === 1'b1) seen.push_back(ack_num);
		end
		@(negedge sys_clk);
		take_en = 1'b0;
		chk("ack_count", e.size(), seen.size());
		foreach (e[i]) chk("ack_order", e[i], seen[i]);
	endtask : drain

	task automatic t_boot;
		int n;
		n = 0;
		wr_ram_early: begin
			vtab_ram = 1'b1;
			vtab_wr = 1'b1;
		end
		while (boot_act === 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		vtab_wr = 1'b0;
		vtab_ram = 1'b0;
		chk("boot_cycles", BOOT_ROM_CYCLES, n);
		chk("vtab_sel", 32'h0, vtab_sel);
		wait_num(EXC_RESET, FLASH_RESET_VEC);
		drain(12, '{EXC_RESET});
	endtask : t_boot

	task automatic t_order;
		pulse_svc: wr(svc_ins, svc_bit, 1'b0);
		icsr(5'h08);
		wr(bad_f, svc_bit, 1'b0);
		icsr(5'h10);
		chk("fault_pend", 32'h1, flt_ps);
		drain(60, '{EXC_NMI, EXC_FAULT, EXC_SVC, EXC_DEFER});
		wr(undef_f, svc_bit, 1'b0);
		wait_num(EXC_FAULT, 32'h0000_000c);
		drain(12, '{EXC_FAULT});
	endtask : t_order

	// svc 3, deferred 1, tick 2; then svc 1, deferred 2, tick 0
	task automatic t_prio;
		hpr2 = 32'hc000_0000;
		hpr3 = 32'h8040_0000;
		wr(svc_ins, svc_bit, 1'b0);
		icsr(5'h0a);
		drain(40, '{EXC_DEFER, EXC_TICK, EXC_SVC});
		hpr2 = 32'h4000_0000;
		hpr3 = 32'h0080_0000;
		wr(svc_ins, svc_bit, 1'b0);
		icsr(5'h0a);
		drain(40, '{EXC_TICK, EXC_SVC, EXC_DEFER});
		hpr2 = 32'h0;
		hpr3 = 32'h0;
	endtask : t_prio

	task automatic t_bits;
		wr(svc_ins, svc_bit, 1'b0);
		chk("svc_pend", 32'h1, svc_ps);
		wr(handler_control_state_reg_wr, svc_bit, 1'b0);
		chk("svc_pend", 32'h0, svc_ps);
		wr(handler_control_state_reg_wr, svc_bit, 1'b1);
		chk("svc_pend", 32'h1, svc_ps);
		wr(handler_control_state_reg_wr, svc_bit, 1'b0);
		icsr(5'h0a);
		icsr(5'h00);
		chk("pend_after_zero", 32'h3, {nmi_ps, def_ps, tk_ps});
		icsr(5'h05);
		chk("pend_after_clear", 32'h0, {svc_ps, def_ps, tk_ps});
	endtask : t_bits

	task automatic t_nmi;
		wr(vtab_wr, vtab_ram, 1'b1);
		chk("vtab_sel", 32'h1, vtab_sel);
		icsr(5'h10);
		wait_num(EXC_NMI, SRAM_BASE + 32'h8);
		chk("vec_rom", 32'h0, vec_rom);
		drain(12, '{EXC_NMI});
		wr(sysreq_wr, sys_bit, 1'b1);
		chk("syscall_pend", 32'h1, sys_ps);
		wait_num(EXC_NMI, BOOT_ROM_NMI_VEC);
		chk("vec_rom", 32'h1, vec_rom);
		drain(12, '{EXC_NMI});
		chk("syscall_pend", 32'h0, sys_ps);
		wr(vtab_wr, vtab_ram, 1'b0);
	endtask : t_nmi

	task automatic t_tick;
		reload = 24'h000003;
		tick_en = 1'b1;
		cyc(14);
		chk("tick_pend", 32'h0, tk_ps);
		repeat (10) if (tick_cnt !== 24'h1) cyc(1);
		cyc(1);
		chk("tick_count", 32'h0, tick_cnt);
		tick_ie = 1'b1;
		cyc(5);
		chk("tick_pend", 32'h1, tk_ps);
		tick_en = 1'b0;
		tick_ie = 1'b0;
		icsr(5'h01);
		chk("tick_pend", 32'h0, tk_ps);
		chk("tick_count", 32'h3, tick_cnt);
		tick_clr = 1'b1;
		cyc(1);
		tick_clr = 1'b0;
		chk("tick_count", 32'h0, tick_cnt);
	endtask : t_tick

	// every line is raised by one of its status bits and dropped before the core takes its handler
	task automatic t_irq;
		for (int k = 0; k < 16; k++) begin
			line_st[k] = 4'h1 << (k % 4);
			wait_num(ses_exc_num_type'(16 + k), 32'(64 + 4 * k));
			chk("irq_pend", 32'h1 << k, irq_ps);
			line_st[k] = 4'h0;
			drain(12, '{ses_exc_num_type'(16 + k)});
		end
		// a held level reruns the handler; the rerun pended at the last return is served once
		cyc(1);
		line_st[4] = 4'h8;
		drain(14, '{EXC_GPIO_ALL, EXC_GPIO_ALL});
		cyc(1);
		line_st[4] = 4'h0;
		drain(12, '{EXC_GPIO_ALL});
		chk("irq_pend", 32'h0, irq_ps);
	endtask : t_irq

	task automatic print_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	// watchdog far beyond the several hundred cycles the tests need
	initial begin
		#500us;
		fail_count++;
		print_verdict();
	end

	// main sequence
	initial begin
		sys_clk = 1'b0;
		rst_b = 1'b0;
		take_en = 1'b0;
		{icsr_wr, nmi_set, def_set, def_clr, tk_set, tk_clr, handler_control_state_reg_wr, svc_bit} = 8'h00;
		{sysreq_wr, sys_bit, vtab_wr, vtab_ram, undef_f, bad_f, svc_ins} = 7'h00;
		{tick_en, tick_ie, tick_clr} = 3'h0;
		{hpr2, hpr3, irq_prio} = 96'h0;
		irq_en = 16'hffff;
		reload = 24'h0;
		line_st = 64'h0;
		cyc(16);
		rst_b = 1'b1;
		t_boot();
		t_order();
		t_prio();
		t_bits();
		t_nmi();
		t_tick();
		t_irq();
		print_verdict();
	end
endmodule : system_exception_sources_tb
`default_nettype wire

// File: hdl/ses_arb_if.sv
// carrier between the exception source logic and its priority arbiter
`timescale 1ns/1ps
`default_nettype none
interface ses_arb_if;
	logic [31:0] pend;
	ses_pkg::ses_prio_type [31:0] prio;
	logic win_valid;
	ses_pkg::ses_exc_num_type win_num;

	modport arb (input pend, input prio, output win_valid, output win_num);
	modport ctl (output pend, output prio, input win_valid, input win_num);
endinterface : ses_arb_if
`default_nettype wire

// File: hdl/ses_exc_top.sv
// system exception sources and peripheral line mapping of the interrupt controller
// Operation
// - reset is an exception that cannot be disabled, fixed priority -3
// - after the boot rom sequence, fetch the startup location from flash word 0x4
// - leave reset with the flash vector table selected; ram reset entry unused
// - non-maskable interrupt is always enabled, fixed priority -2, below reset only
// - nmi pend-set bit raises nmi through the active vector table
// - system call request bit raises nmi whose handler lives in boot rom
// - catch-all fault always enabled, priority -1, raised by undefined instruction or bad address
// - no fault status given; the fault handler may still return
// - supervisor call instruction pends its exception; priority in reg2 bits 31:30
// - supervisor call pended bit shows that pending state and software may change it
// - deferred service set bit pends it, clear bit removes the pending state
// - deferred service priority 0-3 sits in reg3 bits 23:22
// - 24-bit tick down-counter raises tick exception at zero when enabled
// - tick priority 0-3 sits in reg3 bits 31:30
// - tick pending set bit pends the tick exception, clear bit unpends it
// - 16 peripheral lines 0-15 map onto exception numbers 16-31
// - lines: gpio ports, all-port gpio, comparator, watchdog, serial, programming, sensing, timers
// - each line is the or of its peripheral status conditions
// - lower configurable priority value wins, 0 highest, 3 lowest
// - equal priorities go to the lowest exception number
`timescale 1ns/1ps
`default_nettype none
module ses_exc_top #(
	parameter int STAT_W = ses_pkg::IRQ_STAT_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// processor core request and acknowledge
	output logic boot_rom_active,
	output logic exc_req,
	output ses_pkg::ses_exc_num_type exc_num,
	output logic [31:0] exc_vector_addr,
	output logic exc_vector_boot_rom,
	input wire logic exc_ack,
	input wire ses_pkg::ses_exc_num_type exc_ack_num,
	input wire logic exc_return,
	input wire ses_pkg::ses_exc_num_type exc_return_num,
	// core fault and instruction events
	input wire logic undef_instr_fault,
	input wire logic bad_addr_fault,
	input wire logic supervisor_call_instruction,
	// interrupt control state write strobe and bits
	input wire logic icsr_wr,
	input wire logic nmi_pend_set_bit,
	input wire logic deferred_service_set_bit,
	input wire logic deferred_service_clear_bit,
	input wire logic tick_pending_set,
	input wire logic tick_pending_clear,
	// handler control state write strobe and bit
	input wire logic handler_control_state_reg_wr,
	input wire logic supervisor_call_pended_bit,
	// system request write strobe and bit
	input wire logic sysreq_wr,
	input wire logic system_call_request_bit,
	// vector table select
	input wire logic vtab_wr,
	input wire logic vtab_ram_select,
	// priorities and enables
	input wire logic [31:0] handler_priority_reg2,
	input wire logic [31:0] handler_priority_reg3,
	input wire logic [31:0] irq_priority,
	input wire logic [15:0] irq_enable,
	// tick timer control
	input wire logic tick_enable,
	input wire logic tick_interrupt_enable,
	input wire logic tick_count_clear,
	input wire logic [ses_pkg::TICK_W-1:0] tick_reload,
	// peripheral status conditions
	input wire logic [3:0][STAT_W-1:0] gpio_port_status,
	input wire logic [STAT_W-1:0] gpio_all_status,
	input wire logic [STAT_W-1:0] comparator_status,
	input wire logic [STAT_W-1:0] watchdog_status,
	input wire logic [1:0][STAT_W-1:0] serial_status,
	input wire logic [STAT_W-1:0] programming_interface_status,
	input wire logic [STAT_W-1:0] capacitive_sensing_status,
	input wire logic [4:0][STAT_W-1:0] timer_status,
	// pending state readback
	output logic nmi_pend_state,
	output logic system_call_state,
	output logic fault_pend_state,
	output logic supervisor_call_pend_state,
	output logic deferred_service_pend_state,
	output logic tick_pend_state,
	output logic [15:0] irq_pend_state,
	output logic vtab_ram_selected,
	output logic [ses_pkg::TICK_W-1:0] tick_count
);
	import ses_pkg::*;

	logic [7:0] boot_cnt_r, boot_cnt_nxt;
	logic rst_pend_r, rst_pend_nxt;
	logic nmi_pend_r, nmi_pend_nxt;
	logic nmi_sys_r, nmi_sys_nxt;
	logic fault_pend_r, fault_pend_nxt;
	logic svc_pend_r, svc_pend_nxt;
	logic defer_pend_r, defer_pend_nxt;
	logic tick_pend_r, tick_pend_nxt;
	logic vtab_ram_r, vtab_ram_nxt;
	logic [15:0] irq_pend_r, irq_pend_nxt;
	logic [15:0] irq_act_r, irq_act_nxt;
	logic [15:0] line_q_r;
	logic [15:0] line_now;
	logic exc_req_r, exc_req_nxt;
	ses_exc_num_type exc_num_r, exc_num_nxt;
	logic [31:0] exc_vec_r, exc_vec_nxt;
	logic exc_boot_r, exc_boot_nxt;
	logic boot_busy;
	logic tick_zero;
	logic [15:0][STAT_W-1:0] line_stat;
	logic [31:0] table_base;

	ses_arb_if arb_bus ();

	// acknowledge decode for one exception number
	function automatic logic ack_of(input ses_exc_num_type num);
		return exc_ack && (exc_ack_num == num);
	endfunction : ack_of

	// boot rom runs first; no exception is offered until it ends
	assign boot_busy = (boot_cnt_r != 8'h00);
	always_comb begin
		boot_cnt_nxt = boot_busy ? boot_cnt_r - 8'h01 : boot_cnt_r;
	end

	// peripheral line assignment, timers on top, gpio ports at the bottom
	assign line_stat = {timer_status, capacitive_sensing_status,
		programming_interface_status, serial_status, watchdog_status,
		comparator_status, gpio_all_status, gpio_port_status};

	// per line: or of its conditions, edge capture, active tracking
	generate
		for (genvar i = 0; i < IRQ_LINES; i++) begin : g_line
			logic rise;
			logic ret;
			logic ack;
			assign line_now[i] = |line_stat[i];
			assign rise = line_now[i] & ~line_q_r[i];
			assign ret = exc_return && (exc_return_num == EXC_IRQ_BASE + 5'(i));
			// decoded in place: a function call here would not follow the ack inputs
			assign ack = exc_ack && (exc_ack_num == EXC_IRQ_BASE + 5'(i));
			assign irq_act_nxt[i] = (irq_act_r[i] | ack) & ~ret;
			// a level still high at return of an active handler pends again; edges beat the ack
			assign irq_pend_nxt[i] = (irq_pend_r[i] & ~ack) | rise
				| (ret & irq_act_r[i] & line_now[i]);
		end
	endgenerate

	// system exception pending state; every set beats a same-cycle clear, except a supervisor call pended bit write, which an ack overrides
	always_comb begin
		rst_pend_nxt = rst_pend_r & ~ack_of(EXC_RESET);
		nmi_pend_nxt = (nmi_pend_r & ~ack_of(EXC_NMI))
			| (icsr_wr & nmi_pend_set_bit)
			| (sysreq_wr & system_call_request_bit);
		nmi_sys_nxt = (nmi_sys_r & ~ack_of(EXC_NMI)) | (sysreq_wr & system_call_request_bit);
		// only the event lands here; the cause is not kept for the handler
		fault_pend_nxt = (fault_pend_r & ~ack_of(EXC_FAULT))
			| undef_instr_fault | bad_addr_fault;
		svc_pend_nxt = svc_pend_r;
		if (handler_control_state_reg_wr) begin
			svc_pend_nxt = supervisor_call_pended_bit;
		end
		if (ack_of(EXC_SVC)) begin
			svc_pend_nxt = 1'b0;
		end
		if (supervisor_call_instruction) begin
			svc_pend_nxt = 1'b1;
		end
		defer_pend_nxt = defer_pend_r;
		if ((icsr_wr && deferred_service_clear_bit) || ack_of(EXC_DEFER)) begin
			defer_pend_nxt = 1'b0;
		end
		if (icsr_wr && deferred_service_set_bit) begin
			defer_pend_nxt = 1'b1;
		end
		tick_pend_nxt = tick_pend_r;
		if ((icsr_wr && tick_pending_clear) || ack_of(EXC_TICK)) begin
			tick_pend_nxt = 1'b0;
		end
		if ((icsr_wr && tick_pending_set) || (tick_zero && tick_interrupt_enable)) begin
			tick_pend_nxt = 1'b1;
		end
		// startup code alone may move the table, so writes during boot are dropped
		vtab_ram_nxt = (vtab_wr && !boot_busy) ? vtab_ram_select : vtab_ram_r;
	end

	// arbitration inputs; fixed codes keep reset, nmi and fault above all others
	always_comb begin
		arb_bus.pend = '0;
		arb_bus.prio = {EXC_COUNT{PRIO_NONE}};
		if (!boot_busy) begin
			arb_bus.pend[EXC_RESET] = rst_pend_r;
			arb_bus.pend[EXC_NMI] = nmi_pend_r;
			arb_bus.pend[EXC_FAULT] = fault_pend_r;
			arb_bus.pend[EXC_SVC] = svc_pend_r;
			arb_bus.pend[EXC_DEFER] = defer_pend_r;
			arb_bus.pend[EXC_TICK] = tick_pend_r;
			arb_bus.pend[31:16] = irq_pend_r & irq_enable;
		end
		arb_bus.prio[EXC_RESET] = PRIO_RESET;
		arb_bus.prio[EXC_NMI] = PRIO_NMI;
		arb_bus.prio[EXC_FAULT] = PRIO_FAULT;
		arb_bus.prio[EXC_SVC] = PRIO_CFG_BIAS
			+ {1'b0, handler_priority_reg2[SVC_PRIO_LSB +: PRIO_FIELD_W]};
		arb_bus.prio[EXC_DEFER] = PRIO_CFG_BIAS
			+ {1'b0, handler_priority_reg3[DEFER_PRIO_LSB +: PRIO_FIELD_W]};
		arb_bus.prio[EXC_TICK] = PRIO_CFG_BIAS
			+ {1'b0, handler_priority_reg3[TICK_PRIO_LSB +: PRIO_FIELD_W]};
		for (int k = 0; k < IRQ_LINES; k++) begin
			arb_bus.prio[16 + k] = PRIO_CFG_BIAS
				+ {1'b0, irq_priority[k * PRIO_FIELD_W +: PRIO_FIELD_W]};
		end
	end

	ses_prio_arb u_arb (
		.arb(arb_bus.arb)
	);

	ses_tick_timer #(
		.W(TICK_W)
	) u_tick (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick_enable(tick_enable),
		.count_clear(tick_count_clear),
		.reload_value(tick_reload),
		.count(tick_count),
		.zero_evt(tick_zero)
	);

	// request toward the core; dropped the cycle after an ack so it is not offered twice
	assign table_base = vtab_ram_r ? SRAM_BASE : FLASH_BASE;
	always_comb begin
		exc_req_nxt = arb_bus.win_valid & ~exc_ack & ~boot_busy;
		exc_num_nxt = arb_bus.win_num;
		exc_boot_nxt = 1'b0;
		exc_vec_nxt = table_base + {25'h0000000, arb_bus.win_num, 2'b00};
		if (arb_bus.win_num == EXC_RESET) begin
			exc_vec_nxt = FLASH_RESET_VEC;
		end else if (arb_bus.win_num == EXC_NMI && nmi_sys_r) begin
			exc_vec_nxt = BOOT_ROM_NMI_VEC;
			exc_boot_nxt = 1'b1;
		end
	end

	// state registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_cnt_r <= BOOT_ROM_CYCLES;
			rst_pend_r <= 1'b1;
			nmi_pend_r <= 1'b0;
			nmi_sys_r <= 1'b0;
			fault_pend_r <= 1'b0;
			svc_pend_r <= 1'b0;
			defer_pend_r <= 1'b0;
			tick_pend_r <= 1'b0;
			vtab_ram_r <= 1'b0;
			irq_pend_r <= '0;
			irq_act_r <= '0;
			line_q_r <= '0;
			exc_req_r <= 1'b0;
			exc_num_r <= '0;
			exc_vec_r <= '0;
			exc_boot_r <= 1'b0;
		end else begin
			boot_cnt_r <= boot_cnt_nxt;
			rst_pend_r <= rst_pend_nxt;
			nmi_pend_r <= nmi_pend_nxt;
			nmi_sys_r <= nmi_sys_nxt;
			fault_pend_r <= fault_pend_nxt;
			svc_pend_r <= svc_pend_nxt;
			defer_pend_r <= defer_pend_nxt;
			tick_pend_r <= tick_pend_nxt;
			vtab_ram_r <= vtab_ram_nxt;
			irq_pend_r <= irq_pend_nxt;
			irq_act_r <= irq_act_nxt;
			line_q_r <= line_now;
			exc_req_r <= exc_req_nxt;
			exc_num_r <= exc_num_nxt;
			exc_vec_r <= exc_vec_nxt;
			exc_boot_r <= exc_boot_nxt;
		end
	end

	// outputs, all straight from flip-flops except boot_rom_active, decoded from the boot count
	assign boot_rom_active = boot_busy;
	assign exc_req = exc_req_r;
	assign exc_num = exc_num_r;
	assign exc_vector_addr = exc_vec_r;
	assign exc_vector_boot_rom = exc_boot_r;
	assign nmi_pend_state = nmi_pend_r;
	assign system_call_state = nmi_sys_r;
	assign fault_pend_state = fault_pend_r;
	assign supervisor_call_pend_state = svc_pend_r;
	assign deferred_service_pend_state = defer_pend_r;
	assign tick_pend_state = tick_pend_r;
	assign irq_pend_state = irq_pend_r;
	assign vtab_ram_selected = vtab_ram_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_sysreq;
		sysreq_wr && system_call_request_bit && !exc_ack;
	endsequence
	sequence s_gpio_all_rise;
		!line_now[4] ##1 line_now[4] && irq_enable[4] && !exc_ack && !boot_busy;
	endsequence

	AST_RESET_TOP: assert property (rst_pend_r && !boot_busy |-> arb_bus.win_num == EXC_RESET)
		else $error("reset pending but not winning");
	AST_RESET_VEC: assert property (exc_req && exc_num == EXC_RESET
		|-> exc_vector_addr == FLASH_RESET_VEC && !exc_vector_boot_rom)
		else $error("reset vector not taken from flash word four");
	AST_FLASH_AT_BOOT: assert property (boot_busy |-> !vtab_ram_r)
		else $error("ram vector table selected during boot");
	AST_NMI_OVER: assert property (nmi_pend_r && !rst_pend_r && !boot_busy
		|-> arb_bus.win_num == EXC_NMI)
		else $error("nmi pending but lost arbitration");
	AST_NMI_SET: assert property (icsr_wr && nmi_pend_set_bit |=> nmi_pend_r)
		else $error("nmi pend-set write did not pend nmi");
	AST_SYSCALL: assert property (s_sysreq ##1 (!rst_pend_r && !boot_busy && !exc_ack)
		|=> exc_req && exc_num == EXC_NMI && exc_vector_addr == BOOT_ROM_NMI_VEC)
		else $error("system call nmi not sent to boot rom handler");
	AST_FAULT: assert property (undef_instr_fault || bad_addr_fault |=> fault_pend_r)
		else $error("fault event not pended");
	AST_SVC: assert property (supervisor_call_instruction |=> svc_pend_r)
		else $error("supervisor call not pended");
	AST_SVC_WR: assert property (handler_control_state_reg_wr && !supervisor_call_instruction && !exc_ack
		|=> svc_pend_r == $past(supervisor_call_pended_bit))
		else $error("supervisor call pended bit not written");
	AST_DEFER_CLR: assert property (icsr_wr && deferred_service_clear_bit
		&& !deferred_service_set_bit |=> !defer_pend_r)
		else $error("deferred service clear ignored");
	AST_TICK: assert property (tick_zero && tick_interrupt_enable |=> tick_pend_r)
		else $error("tick reaching zero did not pend");
	AST_TICK_CLR: assert property (icsr_wr && tick_pending_clear && !tick_pending_set
		&& !(tick_zero && tick_interrupt_enable) |=> !tick_pend_r)
		else $error("tick pending clear ignored");
	AST_GPIO_ALL: assert property (s_gpio_all_rise |=> irq_pend_r[4]
		&& arb_bus.pend[EXC_GPIO_ALL])
		else $error("all-port gpio line not pending on exception twenty");
	AST_ACK_DROP: assert property (exc_ack |=> !exc_req)
		else $error("request held after acknowledge");
endmodule : ses_exc_top
`default_nettype wire

// File: hdl/ses_pkg.sv
// shared constants and types of the system exception source logic
`default_nettype none
package ses_pkg;
	typedef logic [4:0] ses_exc_num_type;
	typedef logic [2:0] ses_prio_type;

	// exception numbers
	localparam int EXC_COUNT = 32;
	localparam ses_exc_num_type EXC_RESET = 5'h01;
	localparam ses_exc_num_type EXC_NMI = 5'h02;
	localparam ses_exc_num_type EXC_FAULT = 5'h03;
	localparam ses_exc_num_type EXC_SVC = 5'h0b;
	localparam ses_exc_num_type EXC_DEFER = 5'h0e;
	localparam ses_exc_num_type EXC_TICK = 5'h0f;
	localparam ses_exc_num_type EXC_IRQ_BASE = 5'h10;
	localparam ses_exc_num_type EXC_GPIO_ALL = 5'h14;

	// priority codes are biased by three so -3..3 stay unsigned: -3 -> 0, 3 -> 6
	localparam ses_prio_type PRIO_RESET = 3'h0;
	localparam ses_prio_type PRIO_NMI = 3'h1;
	localparam ses_prio_type PRIO_FAULT = 3'h2;
	localparam ses_prio_type PRIO_CFG_BIAS = 3'h3;
	localparam ses_prio_type PRIO_NONE = 3'h7;

	// configurable priority field positions
	localparam int SVC_PRIO_LSB = 30;
	localparam int DEFER_PRIO_LSB = 22;
	localparam int TICK_PRIO_LSB = 30;
	localparam int PRIO_FIELD_W = 2;

	// peripheral lines
	localparam int IRQ_LINES = 16;
	localparam int IRQ_STAT_W = 4;

	// vector addresses
	localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
	localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
	localparam logic [31:0] FLASH_RESET_VEC = 32'h0000_0004;
	// arbitrary boot rom handler entry, stands in for the real one
	localparam logic [31:0] BOOT_ROM_NMI_VEC = 32'h1000_0040;

	// boot rom sequence length and tick timer width
	localparam logic [7:0] BOOT_ROM_CYCLES = 8'h10;
	localparam int TICK_W = 24;
endpackage : ses_pkg
`default_nettype wire

// File: hdl/ses_prio_arb.sv
// priority arbiter over all 32 exception numbers
`timescale 1ns/1ps
`default_nettype none
module ses_prio_arb (
	// pending set and winner
	ses_arb_if.arb arb
);
	import ses_pkg::*;

	// scan upward with a strict compare so a tie keeps the lower number
	always_comb begin
		ses_prio_type best;
		best = PRIO_NONE;
		arb.win_valid = 1'b0;
		arb.win_num = '0;
		for (int i = 0; i < EXC_COUNT; i++) begin
			if (arb.pend[i] && (!arb.win_valid || arb.prio[i] < best)) begin
				best = arb.prio[i];
				arb.win_valid = 1'b1;
				arb.win_num = ses_exc_num_type'(i);
			end
		end
	end
endmodule : ses_prio_arb
`default_nettype wire

// File: hdl/ses_tick_timer.sv
// periodic tick down-counter with reload
`timescale 1ns/1ps
`default_nettype none
module ses_tick_timer #(
	parameter int W = ses_pkg::TICK_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// control
	input wire logic tick_enable,
	input wire logic count_clear,
	input wire logic [W-1:0] reload_value,
	// state
	output logic [W-1:0] count,
	output logic zero_evt
);
	import ses_pkg::*;

	logic [W-1:0] count_r, count_nxt;
	logic zero_r, zero_nxt;

	// reload on zero, else count down; the event marks the step onto zero
	always_comb begin
		count_nxt = count_r;
		zero_nxt = 1'b0;
		if (count_clear) begin
			count_nxt = '0;
		end else if (tick_enable) begin
			if (count_r == '0) begin
				count_nxt = reload_value;
			end else begin
				count_nxt = count_r - 1'b1;
				zero_nxt = (count_r == W'(1));
			end
		end
	end

	// state registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= '0;
			zero_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			zero_r <= zero_nxt;
		end
	end

	assign count = count_r;
	assign zero_evt = zero_r;
endmodule : ses_tick_timer
`default_nettype wire
